// ===== rtl/rptctl_top.sv
`timescale 1ns/1ps
`include "rptctl_regs.svh"

// ==========================================================
// Notes on behaviour
// - Override bit selects register transmit-off per channel
// - Two bits enable fourth equalizer stage
// - CRC check off applies writes immediately
// - CRC check on holds updates until match
// - Bit seven blocks EEPROM self configuration
// - Register reset bit restores defaults, self clears
// - Master reset bit pulses, self clears
// - Threshold override picks channel registers over pin
// - Idle override takes channel idle control
// - Output mode override uses channel bit six
// - Override off keeps normal mode, adjustments allowed
// - Idle select forces, auto bit gives auto
// - Threshold fields act only under override
module rptctl_top (
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    input  wire logic       i_smb_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda_in,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    input  wire logic       i_transmit_off,
    input  wire logic [3:0] i_thr_a,
    input  wire logic [3:0] i_thr_b,
    input  wire logic [1:0] i_idle_ctl_a,
    input  wire logic [1:0] i_idle_ctl_b,
    input  wire logic       i_out_mode_a,
    input  wire logic       i_out_mode_b,
    output logic            o_transmit_off_a,
    output logic            o_transmit_off_b,
    output logic            o_esata_a,
    output logic            o_esata_b,
    output logic [1:0]      o_equalizer_stage_enable,
    output logic            o_thr_by_pin,
    output logic [3:0]      o_idle_thr_a,
    output logic [3:0]      o_idle_thr_b,
    output logic            o_idle_force_a,
    output logic            o_idle_force_b,
    output logic            o_idle_auto_a,
    output logic            o_idle_auto_b,
    output logic            o_out_mode_a,
    output logic            o_out_mode_b,
    output logic            o_swing_adj_en,
    output logic            o_eeprom_cfg_off,
    output logic            o_smb_master_rst,
    output logic            o_upd_pending
);
    import rptctl_pkg::*;

    // ==========================================================
    // Declarations
    logic           txoff_m_r, txoff_s_r;
    logic [7:0]     ctl3_r, crcv_r, crcc_r, rstc_r, pino_r;
    logic [7:0]     act_ctl3_r, act_pino_r, crc_calc;
    logic           pend_r, reg_rst_r;
    logic           wr_pulse, rd_pulse, commit, nochk, wr_dp;
    logic           lrst_m_r, lrst_r;
    logic           scl_m_r, scl_s_r, scl_d_r;
    logic           sda_m_r, sda_s_r, sda_d_r;
    rptctl_smb_st_t st_r;
    logic [3:0]     cnt_r;
    logic [7:0]     sh_r, tx_r, ptr_r;
    logic [7:0]     wr_addr_r, wr_data_r, rd_addr_r, rd_data_r, rdat_r;
    logic           wr_tgl_r, rd_tgl_r, rd_ack_tgl_r, rd_ack_pulse;
    logic           scl_rise, scl_fall, smb_start, smb_stop;

    // ==========================================================
    // Crossings and helpers
    rptctl_tgl_sync u_wr_sync (
        .i_clk   (i_sys_clk),
        .i_rst   (i_srst),
        .i_tgl   (wr_tgl_r),
        .o_pulse (wr_pulse)
    );

    rptctl_tgl_sync u_rd_sync (
        .i_clk   (i_sys_clk),
        .i_rst   (i_srst),
        .i_tgl   (rd_tgl_r),
        .o_pulse (rd_pulse)
    );

    rptctl_tgl_sync u_ack_sync (
        .i_clk   (i_smb_clk),
        .i_rst   (lrst_r),
        .i_tgl   (rd_ack_tgl_r),
        .o_pulse (rd_ack_pulse)
    );

    rptctl_crc8 u_crc (
        .i_data ({ctl3_r, pino_r}),
        .o_crc  (crc_calc)
    );

    // ==========================================================
    // System domain: register file
    assign nochk  = crcc_r[`RPTCTL_B_NOCHK];
    assign wr_dp  = wr_pulse && (wr_addr_r == `RPTCTL_OFS_CTL3 ||
                                 wr_addr_r == `RPTCTL_OFS_PINO);
    // Host CRC matches the pending settings
    assign commit = wr_pulse && wr_addr_r == `RPTCTL_OFS_CRCV &&
                    wr_data_r == crc_calc;

    // Transmit-off pin synchroniser
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            txoff_m_r <= 1'b0;
            txoff_s_r <= 1'b0;
        end else begin
            txoff_m_r <= i_transmit_off;
            txoff_s_r <= txoff_m_r;
        end
    end

    // Writable registers, only reached from the SMBus slave
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || reg_rst_r) begin
            ctl3_r <= `RPTCTL_RST_CTL3;
            crcv_r <= `RPTCTL_RST_CRCV;
            crcc_r <= `RPTCTL_RST_CRCC;
            rstc_r <= `RPTCTL_RST_RSTC;
            pino_r <= `RPTCTL_RST_PINO;
        end else if (wr_pulse) begin
            case (wr_addr_r)
                `RPTCTL_OFS_CTL3: ctl3_r <= wr_data_r;
                `RPTCTL_OFS_CRCV: crcv_r <= wr_data_r;
                `RPTCTL_OFS_CRCC: crcc_r <= wr_data_r;
                `RPTCTL_OFS_RSTC: rstc_r <= wr_data_r & 8'h9f;
                `RPTCTL_OFS_PINO: pino_r <= wr_data_r;
                default: ;
            endcase
        end
    end

    // Self clearing reset strobes
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            reg_rst_r        <= 1'b0;
            o_smb_master_rst <= 1'b0;
        end else begin
            reg_rst_r        <= wr_pulse && wr_addr_r == `RPTCTL_OFS_RSTC &&
                                wr_data_r[`RPTCTL_B_RST_REGS];
            o_smb_master_rst <= wr_pulse && wr_addr_r == `RPTCTL_OFS_RSTC &&
                                wr_data_r[`RPTCTL_B_RST_MSTR];
        end
    end

    // Settings seen by the data path
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || reg_rst_r) begin
            act_ctl3_r <= `RPTCTL_RST_CTL3;
            act_pino_r <= `RPTCTL_RST_PINO;
        end else if (nochk || commit) begin
            act_ctl3_r <= ctl3_r;
            act_pino_r <= pino_r;
        end
    end

    // Pending flag; a new write wins over a commit
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || reg_rst_r || nochk) begin
            pend_r <= 1'b0;
        end else if (wr_dp) begin
            pend_r <= 1'b1;
        end else if (commit) begin
            pend_r <= 1'b0;
        end
    end

    // Read answer to the link domain
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_data_r    <= 8'h00;
            rd_ack_tgl_r <= 1'b0;
        end else if (rd_pulse) begin
            rd_ack_tgl_r <= ~rd_ack_tgl_r;
            case (rd_addr_r)
                `RPTCTL_OFS_CTL3: rd_data_r <= ctl3_r;
                `RPTCTL_OFS_CRCV: rd_data_r <= crcv_r;
                `RPTCTL_OFS_CRCC: rd_data_r <= {crcc_r[7:1], pend_r};
                `RPTCTL_OFS_RSTC: rd_data_r <= rstc_r;
                `RPTCTL_OFS_PINO: rd_data_r <= pino_r;
                default:          rd_data_r <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // System domain: data path controls
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_transmit_off_a         <= 1'b0;
            o_transmit_off_b         <= 1'b0;
            o_esata_a                <= 1'b0;
            o_esata_b                <= 1'b0;
            o_equalizer_stage_enable <= 2'h0;
        end else begin
            o_transmit_off_a <= act_ctl3_r[`RPTCTL_B_TXOFF_OVR] ?
                                act_ctl3_r[`RPTCTL_B_TXOFF_A] : txoff_s_r;
            o_transmit_off_b <= act_ctl3_r[`RPTCTL_B_TXOFF_OVR] ?
                                act_ctl3_r[`RPTCTL_B_TXOFF_B] : txoff_s_r;
            o_esata_a        <= act_ctl3_r[`RPTCTL_B_ESATA_A];
            o_esata_b        <= act_ctl3_r[`RPTCTL_B_ESATA_B];
            o_equalizer_stage_enable <= {act_ctl3_r[`RPTCTL_B_EQ_B],
                                         act_ctl3_r[`RPTCTL_B_EQ_A]};
        end
    end

    // Pin override resolution for idle and output mode
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_thr_by_pin   <= 1'b1;
            o_idle_thr_a   <= 4'h0;
            o_idle_thr_b   <= 4'h0;
            o_idle_force_a <= 1'b0;
            o_idle_force_b <= 1'b0;
            o_idle_auto_a  <= 1'b0;
            o_idle_auto_b  <= 1'b0;
            o_out_mode_a   <= 1'b0;
            o_out_mode_b   <= 1'b0;
            o_swing_adj_en <= 1'b1;
        end else begin
            o_thr_by_pin   <= ~act_pino_r[`RPTCTL_B_OVR_THR];
            o_idle_thr_a   <= act_pino_r[`RPTCTL_B_OVR_THR] ? i_thr_a : 4'h0;
            o_idle_thr_b   <= act_pino_r[`RPTCTL_B_OVR_THR] ? i_thr_b : 4'h0;
            o_idle_force_a <= act_pino_r[`RPTCTL_B_OVR_IDLE] & i_idle_ctl_a[0];
            o_idle_force_b <= act_pino_r[`RPTCTL_B_OVR_IDLE] & i_idle_ctl_b[0];
            o_idle_auto_a  <= act_pino_r[`RPTCTL_B_OVR_IDLE] & i_idle_ctl_a[1];
            o_idle_auto_b  <= act_pino_r[`RPTCTL_B_OVR_IDLE] & i_idle_ctl_b[1];
            o_out_mode_a   <= act_pino_r[`RPTCTL_B_OVR_OUT] & i_out_mode_a;
            o_out_mode_b   <= act_pino_r[`RPTCTL_B_OVR_OUT] & i_out_mode_b;
            o_swing_adj_en <= ~act_pino_r[`RPTCTL_B_OVR_OUT];
        end
    end

    // Loader disable and pending status
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_eeprom_cfg_off <= 1'b0;
            o_upd_pending    <= 1'b0;
        end else begin
            o_eeprom_cfg_off <= crcc_r[`RPTCTL_B_EE_OFF];
            o_upd_pending    <= pend_r;
        end
    end

    // ==========================================================
    // Link domain: reset and pin synchronisers
    always_ff @(posedge i_smb_clk) begin
        lrst_m_r <= i_srst;
        lrst_r   <= lrst_m_r;
    end

    always_ff @(posedge i_smb_clk) begin
        if (lrst_r) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= i_scl;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= i_sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    assign scl_rise  = scl_s_r & ~scl_d_r;
    assign scl_fall  = ~scl_s_r & scl_d_r;
    assign smb_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign smb_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

    // Read data captured from the system domain
    always_ff @(posedge i_smb_clk) begin
        if (lrst_r) begin
            rdat_r <= 8'h00;
        end else if (rd_ack_pulse) begin
            rdat_r <= rd_data_r;
        end
    end

    // ==========================================================
    // Link domain: SMBus slave byte engine
    always_ff @(posedge i_smb_clk) begin
        if (lrst_r) begin
            st_r      <= st_idle;
            cnt_r     <= 4'h0;
            sh_r      <= 8'h00;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            wr_tgl_r  <= 1'b0;
            rd_addr_r <= 8'h00;
            rd_tgl_r  <= 1'b0;
            o_sda_oe  <= 1'b0;
            o_sda_out <= 1'b0;
        end else if (smb_start) begin
            st_r     <= st_addr;
            cnt_r    <= 4'hf; // Start's own clock fall wraps this to zero
            o_sda_oe <= 1'b0;
        end else if (smb_stop) begin
            st_r     <= st_idle;
            o_sda_oe <= 1'b0;
        end else if (st_r != st_idle && scl_rise) begin
            if (cnt_r != `RPTCTL_ACK_BIT) begin
                sh_r <= {sh_r[6:0], sda_s_r};
            end else if (st_r == st_rd && !o_sda_oe) begin
                if (sda_s_r) begin
                    st_r <= st_idle; // Host ended the read
                end else begin
                    rd_addr_r <= ptr_r;
                    ptr_r     <= ptr_r + 8'h01;
                    rd_tgl_r  <= ~rd_tgl_r;
                end
            end
        end else if (st_r != st_idle && scl_fall) begin
            cnt_r <= (cnt_r == `RPTCTL_ACK_BIT) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r == 4'h7) begin
                // Byte complete: decide acknowledge
                case (st_r)
                    st_addr: begin
                        if (sh_r[7:1] == `RPTCTL_SLAVE_ADDR) begin
                            o_sda_oe <= 1'b1;
                            st_r     <= sh_r[0] ? st_rd : st_reg;
                            if (sh_r[0]) begin
                                rd_addr_r <= ptr_r;
                                ptr_r     <= ptr_r + 8'h01;
                                rd_tgl_r  <= ~rd_tgl_r;
                            end
                        end else begin
                            st_r <= st_idle;
                        end
                    end
                    st_reg: begin
                        ptr_r    <= sh_r;
                        o_sda_oe <= 1'b1;
                        st_r     <= st_wr;
                    end
                    st_wr: begin
                        wr_addr_r <= ptr_r;
                        wr_data_r <= sh_r;
                        wr_tgl_r  <= ~wr_tgl_r;
                        ptr_r     <= ptr_r + 8'h01;
                        o_sda_oe  <= 1'b1;
                    end
                    default: o_sda_oe <= 1'b0;
                endcase
            end else if (cnt_r == `RPTCTL_ACK_BIT) begin
                // Leave the acknowledge slot
                if (st_r == st_rd) begin
                    o_sda_oe <= ~rdat_r[7];
                    tx_r     <= {rdat_r[6:0], 1'b0};
                end else begin
                    o_sda_oe <= 1'b0;
                end
            end else if (st_r == st_rd) begin
                o_sda_oe <= ~tx_r[7];
                tx_r     <= {tx_r[6:0], 1'b0};
            end
        end
    end
endmodule // rptctl_top

// ===== inc/rptctl_regs.svh
`ifndef RPTCTL_REGS_SVH
`define RPTCTL_REGS_SVH

// ==========================================================
// Register offsets
`define RPTCTL_OFS_CTL3      8'h04
`define RPTCTL_OFS_CRCV      8'h05
`define RPTCTL_OFS_CRCC      8'h06
`define RPTCTL_OFS_RSTC      8'h07
`define RPTCTL_OFS_PINO      8'h08

// ==========================================================
// Reset values
`define RPTCTL_RST_CTL3      8'h00
`define RPTCTL_RST_CRCV      8'h00
`define RPTCTL_RST_CRCC      8'h10
`define RPTCTL_RST_RSTC      8'h01
`define RPTCTL_RST_PINO      8'h00

// ==========================================================
// Field positions
`define RPTCTL_B_ESATA_A     7
`define RPTCTL_B_ESATA_B     6
`define RPTCTL_B_TXOFF_OVR   5
`define RPTCTL_B_TXOFF_A     4
`define RPTCTL_B_TXOFF_B     3
`define RPTCTL_B_EQ_B        1
`define RPTCTL_B_EQ_A        0
`define RPTCTL_B_EE_OFF      7
`define RPTCTL_B_NOCHK       3
`define RPTCTL_B_PEND        0
`define RPTCTL_B_RST_REGS    6
`define RPTCTL_B_RST_MSTR    5
`define RPTCTL_B_OVR_THR     6
`define RPTCTL_B_OVR_IDLE    4
`define RPTCTL_B_OVR_OUT     2

// ==========================================================
// Link constants
`define RPTCTL_SLAVE_ADDR    7'h5a
`define RPTCTL_CRC_POLY      8'h07
`define RPTCTL_ACK_BIT       4'h8

`endif

// ===== inc/rptctl_pkg.sv
// ==========================================================
// Types shared by the control block
package rptctl_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_reg,
        st_wr,
        st_rd
    } rptctl_smb_st_t;
endpackage

// ===== rtl/rptctl_tgl_sync.sv
`timescale 1ns/1ps

// ==========================================================
// Toggle to pulse crossing into the i_clk domain
module rptctl_tgl_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_tgl,
    output logic      o_pulse
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Two stage sync, then edge detect on the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r  <= 1'b0;
            sync_r  <= 1'b0;
            last_r  <= 1'b0;
            o_pulse <= 1'b0;
        end else begin
            meta_r  <= i_tgl;
            sync_r  <= meta_r;
            last_r  <= sync_r;
            o_pulse <= sync_r ^ last_r;
        end
    end
endmodule // rptctl_tgl_sync

// ===== rtl/rptctl_crc8.sv
`timescale 1ns/1ps
`include "rptctl_regs.svh"

// ==========================================================
// CRC-8 over the pending data path settings, msb first
module rptctl_crc8 (
    input  wire logic [15:0] i_data,
    output logic [7:0]       o_crc
);
    // Bitwise shift of the polynomial division
    always_comb begin
        o_crc = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            if (o_crc[7] ^ i_data[i]) begin
                o_crc = {o_crc[6:0], 1'b0} ^ `RPTCTL_CRC_POLY;
            end else begin
                o_crc = {o_crc[6:0], 1'b0};
            end
        end
    end
endmodule // rptctl_crc8

// ===== verification/rptctl_checker.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks on the control register block
module rptctl_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_srst,
    input wire logic       i_smb_clk,
    input wire logic       i_scl,
    input wire logic       o_sda_oe,
    input wire logic       o_thr_by_pin,
    input wire logic [3:0] o_idle_thr_a,
    input wire logic [3:0] o_idle_thr_b,
    input wire logic       o_esata_a,
    input wire logic [1:0] o_equalizer_stage_enable,
    input wire logic       o_out_mode_a,
    input wire logic       o_out_mode_b,
    input wire logic       o_swing_adj_en,
    input wire logic       o_smb_master_rst,
    input wire logic       o_upd_pending
);
    // ======================================================
    // System clock domain
    chk_swing_mode: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_swing_adj_en |-> !o_out_mode_a && !o_out_mode_b)
        else $error("Output mode forced while override off");
    chk_thr_gate: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_thr_by_pin |-> (o_idle_thr_a == 4'h0) && (o_idle_thr_b == 4'h0))
        else $error("Threshold fields active without override");
    chk_mrst_pulse: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_smb_master_rst |=> !o_smb_master_rst)
        else $error("Master reset pulse longer than one cycle");
    // Reset itself is the cause here, so it cannot disable the check
    chk_reset_defaults: assert property (
        @(posedge i_sys_clk)
        i_srst |=> o_thr_by_pin && o_swing_adj_en && !o_upd_pending
            && !o_smb_master_rst && !o_esata_a && (o_equalizer_stage_enable == 2'h0))
        else $error("Outputs not at defaults after reset");
    chk_pend_freeze: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        o_upd_pending && $past(o_upd_pending) |-> $stable(o_esata_a)
            && $stable(o_equalizer_stage_enable) && $stable(o_thr_by_pin))
        else $error("Outputs moved while update pending");
    chk_pend_hold: assert property (
        @(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_upd_pending) |=> o_upd_pending [*8])
        else $error("Pending update dropped without checksum");
    // ======================================================
    // Link clock domain: data line only moves while clock low
    chk_sda_rise: assert property (
        @(posedge i_smb_clk) disable iff (i_srst)
        $rose(o_sda_oe) |-> !i_scl)
        else $error("Data line pulled while bus clock high");
    chk_sda_fall: assert property (
        @(posedge i_smb_clk) disable iff (i_srst)
        $fell(o_sda_oe) |-> !i_scl)
        else $error("Data line released while bus clock high");
endmodule // rptctl_checker

bind rptctl_top rptctl_checker u_chk (
    .i_sys_clk, .i_srst, .i_smb_clk, .i_scl, .o_sda_oe, .o_thr_by_pin,
    .o_idle_thr_a, .o_idle_thr_b, .o_esata_a, .o_equalizer_stage_enable,
    .o_out_mode_a, .o_out_mode_b, .o_swing_adj_en, .o_smb_master_rst,
    .o_upd_pending
);

// ===== verification/rptctl_host_model.sv
`timescale 1ns/1ps
`include "rptctl_regs.svh"

// ==========================================================
// SMBus host configuring the block through its slave pins
module rptctl_host_model #(
    parameter int P = 500
) (
    input  wire logic i_sda_oe,
    output logic      o_scl,
    output logic      o_sda
);
    logic low_r;

    // Open-drain data line with pull-up
    assign o_sda = ~(i_sda_oe | low_r);

    // Bus idle at time zero
    initial begin
        o_scl = 1'b1;
        low_r = 1'b0;
    end

    // ======================================================
    // Bus conditions; outside start and stop, data moves only well after clock falls
    task automatic start();
        #(P/2) low_r = 1'b0;
        #P o_scl = 1'b1;
        #P low_r = 1'b1;
        #P o_scl = 1'b0;
    endtask

    task automatic stop();
        #(P/2) low_r = 1'b1;
        #P o_scl = 1'b1;
        #P low_r = 1'b0;
        #P;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(P/2) low_r = ~b[i];
            #(P/2) o_scl = 1'b1;
            #P o_scl = 1'b0;
        end
        #(P/2) low_r = 1'b0;
        #(P/2) o_scl = 1'b1;
        #(P/2) ack = ~o_sda;
        #(P/2) o_scl = 1'b0;
    endtask

    task automatic recv(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #P o_scl = 1'b1;
            #(P/2) b[i] = o_sda;
            #(P/2) o_scl = 1'b0;
        end
        #(P/2) low_r = ~nack;
        #(P/2) o_scl = 1'b1;
        #P o_scl = 1'b0;
    endtask

    // ======================================================
    // Register transfers; callers pass reserved bits fixed
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        logic a;
        start();
        send({`RPTCTL_SLAVE_ADDR, 1'b0}, a);
        send(o, a);
        send(d, a);
        stop();
    endtask

    task automatic rd(input logic [7:0] o, output logic [7:0] d);
        logic a;
        start();
        send({`RPTCTL_SLAVE_ADDR, 1'b0}, a);
        send(o, a);
        start();
        send({`RPTCTL_SLAVE_ADDR, 1'b1}, a);
        recv(1'b1, d);
        stop();
    endtask

    task automatic probe(input logic [7:0] b, output logic ack);
        start();
        send(b, ack);
        stop();
    endtask
endmodule // rptctl_host_model

// ===== verification/testbench.sv
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench for the control register block
module testbench;
    logic        clk, srst, smb_clk, scl, sda, oe, ack, sda_o;
    logic        tx_pin, om_a, om_b, mrst, pend, eeoff;
    logic [3:0]  th_a, th_b;
    logic [1:0]  ic_a, ic_b;
    logic [7:0]  c, p;
    logic [7:0]  dflt [5] = '{8'h00, 8'h00, 8'h10, 8'h01, 8'h00};
    wire  [21:0] got;
    int          fails, checks_done, pulses, seed;

    // Clocks; the link clock is unrelated in phase
    always #20 clk = ~clk;
    always #62.5 smb_clk = ~smb_clk;

    rptctl_top DUT (
        .i_sys_clk(clk), .i_srst(srst), .i_smb_clk(smb_clk), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(sda_o), .o_sda_oe(oe), .i_transmit_off(tx_pin),
        .i_thr_a(th_a), .i_thr_b(th_b), .i_idle_ctl_a(ic_a), .i_idle_ctl_b(ic_b),
        .i_out_mode_a(om_a), .i_out_mode_b(om_b),
        .o_transmit_off_a(got[21]), .o_transmit_off_b(got[20]), .o_esata_a(got[19]),
        .o_esata_b(got[18]), .o_equalizer_stage_enable(got[17:16]),
        .o_thr_by_pin(got[15]), .o_idle_thr_a(got[14:11]), .o_idle_thr_b(got[10:7]),
        .o_idle_force_a(got[6]), .o_idle_force_b(got[5]), .o_idle_auto_a(got[4]),
        .o_idle_auto_b(got[3]), .o_out_mode_a(got[2]), .o_out_mode_b(got[1]),
        .o_swing_adj_en(got[0]), .o_eeprom_cfg_off(eeoff), .o_smb_master_rst(mrst),
        .o_upd_pending(pend)
    );

    rptctl_host_model u_host (.i_sda_oe(oe), .o_scl(scl), .o_sda(sda));

    // Count master reset pulses
    always @(posedge clk) begin
        if (mrst === 1'b1) pulses++;
    end

    // ======================================================
    // Expected outputs from active register copies and pins
    function automatic logic [21:0] expo(logic [7:0] r4, logic [7:0] r8);
        return {r4[5] ? r4[4] : tx_pin, r4[5] ? r4[3] : tx_pin, r4[7:6], r4[1:0],
                ~r8[6], r8[6] ? th_a : 4'h0, r8[6] ? th_b : 4'h0,
                r8[4] & ic_a[0], r8[4] & ic_b[0], r8[4] & ic_a[1], r8[4] & ic_b[1],
                r8[2] & om_a, r8[2] & om_b, ~r8[2]};
    endfunction

    // Checksum, polynomial 0x07, zero start, msb first
    function automatic logic [7:0] crc8(logic [15:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 15; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ v[i]) ? 8'h07 : 8'h00);
        return r;
    endfunction

    task automatic chk(string n, logic [21:0] e, logic [21:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdchk(logic [7:0] o, logic [7:0] e);
        logic [7:0] v;
        u_host.rd(o, v);
        chk($sformatf("reg %h", o), e, v);
    endtask

    task automatic settle();
        repeat (20) @(posedge clk);
        #1;
    endtask

    // New random pin levels just after an edge
    task automatic rnd_pins();
        @(posedge clk);
        #1;
        {tx_pin, om_a, om_b, th_a, th_b, ic_a, ic_b} = 15'($urandom);
    endtask

    task automatic wr2(logic [7:0] r4, logic [7:0] r8);
        u_host.wr(8'h04, r4);
        u_host.wr(8'h08, r8);
        settle();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog at about three times the expected run
    initial begin
        #4000000;
        fails++;
        tally_and_finish();
    end

    // ======================================================
    // Main sequence
    initial begin
        {clk, smb_clk, srst, tx_pin, om_a, om_b, th_a, th_b, ic_a, ic_b} = 18'h08000;
        {fails, checks_done, pulses} = '0;
        seed = $urandom(93);
        repeat (13) @(posedge clk);
        #1 srst = 0;
        settle();
        chk("outputs", expo(8'h00, 8'h00), got);
        chk("sda drive level", 1'b0, sda_o);
        for (int i = 0; i < 5; i++) rdchk(8'h04 + 8'(i), dflt[i]);
        rdchk(8'h20, 8'h00);
        u_host.probe(8'h22, ack);
        chk("foreign address ack", 1'b0, ack);
        $display("test defaults done");
        rnd_pins();
        c = 8'($urandom) & 8'hfb;
        p = 8'($urandom) & 8'h54;
        wr2(c, p);
        chk("pending", 1'b1, pend);
        chk("outputs", expo(8'h00, 8'h00), got);
        u_host.wr(8'h05, crc8({c, p}) ^ 8'h01);
        settle();
        chk("pending", 1'b1, pend);
        u_host.wr(8'h05, crc8({c, p}));
        settle();
        chk("pending", 1'b0, pend);
        chk("outputs", expo(c, p), got);
        $display("test checksum gate done");
        u_host.wr(8'h06, 8'h18);
        for (int i = 0; i < 8; i++) begin
            rnd_pins();
            c = (i == 0) ? 8'hfb : (i == 1) ? 8'h00 : 8'($urandom) & 8'hfb;
            p = (i == 0) ? 8'h54 : 8'($urandom) & 8'h54;
            wr2(c, p);
            chk("outputs", expo(c, p), got);
        end
        chk("pending", 1'b0, pend);
        u_host.wr(8'h06, 8'h98);
        settle();
        chk("eeprom off", 1'b1, eeoff);
        rdchk(8'h06, 8'h98);
        $display("test direct mode done");
        u_host.wr(8'h07, 8'h21);
        settle();
        chk("master pulses", 22'h1, 22'(pulses));
        rdchk(8'h07, 8'h01);
        $display("test master reset done");
        u_host.wr(8'h07, 8'h41);
        settle();
        rdchk(8'h04, 8'h00);
        rdchk(8'h06, 8'h10);
        chk("outputs", expo(8'h00, 8'h00), got);
        $display("test register reset done");
        tally_and_finish();
    end
endmodule // testbench
